// ---- design/ret_params.svh ----
/*
 * Register indices, field positions, reset values and limits of the reader event timer.
 * Assumes inclusion by bare name from every design file that decodes or resets registers.
 */
`ifndef RET_PARAMS_SVH
`define RET_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define RET_IDX_AUX_STATUS 8'h05
`define RET_IDX_IRQ_EN 8'h06
`define RET_IDX_IRQ_STAT 8'h07
`define RET_IDX_COMMAND 8'h09
`define RET_IDX_COUNT 8'h0C
`define RET_IDX_TICK_DIV 8'h2A
`define RET_IDX_TRIG_SEL 8'h2B
`define RET_IDX_PRELOAD 8'h2C
`define RET_IDX_IRQ_CLR 8'h30

// Field positions
`define RET_BIT_ACTIVE 7
`define RET_BIT_SW_START 1
`define RET_BIT_SW_STOP 2
`define RET_BIT_EXPIRY 5

// Reset values and limits
`define RET_RST_BYTE 8'h00
`define RET_RST_DIV 6'h00
`define RET_RST_TRIG 4'h0
`define RET_EXP_MAX 5'h15
`define RET_IRQ_IMPL 8'h20
`define RET_PRESC_ONE 22'h000001

`endif

// ---- design/ret_pkg.sv ----
/*
 * Types shared by the reader event timer modules: bus carriers, register fields and state records.
 * Assumes nothing of its surroundings; widths are the documented fixed ones.
 */
package ret_pkg;

	typedef enum logic {st_idle, st_run} ret_run_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [9:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} ret_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ret_apb_rsp_type;

	// Transceiver event pulses, bit 3 first
	typedef struct packed {
		logic rx_last_bit_evt;
		logic rx_first_bit_evt;
		logic tx_last_bit_evt;
		logic tx_first_bit_evt;
	} ret_evt_type;

	typedef struct packed {
		logic stop_on_rx_last_bit;
		logic stop_on_rx_first_bit;
		logic start_on_tx_last_bit;
		logic start_on_tx_first_bit;
	} ret_trig_type;

	typedef struct packed {
		logic auto_reload_en;
		logic [4:0] tick_divider_exp;
	} ret_div_type;

	typedef struct packed {
		logic sw_stop_cmd;
		logic sw_start_cmd;
	} ret_cmd_type;

	typedef struct packed {
		ret_div_type div;
		ret_trig_type trig;
		logic [7:0] preload_field;
		ret_cmd_type cmd;
		logic [7:0] count_field;
		ret_run_type run;
		logic expiry;
		ret_apb_rsp_type rsp;
	} ret_main_state_type;

	typedef struct packed {
		logic [21:0] cnt;
		logic tick;
	} ret_presc_state_type;

	typedef struct packed {
		logic [7:0] stat;
		logic [7:0] en;
		logic irq;
	} ret_irq_state_type;

endpackage

// ---- design/ret_prescaler.sv ----
/*
 * Power-of-two tick divider: one-cycle tick every 2^exp clocks, restartable.
 * Assumes exp and restart come from logic on the same clock.
 */
`include "ret_params.svh"

module ret_prescaler import ret_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic [4:0] exp_val,
	input wire logic restart,
	// Tick out
	output logic tick
);
	ret_presc_state_type s_q, s_d;
	logic [4:0] exp_eff;
	logic [21:0] limit;

	// Out-of-range exponents saturate at the slowest legal rate
	always_comb begin
		exp_eff = (exp_val > `RET_EXP_MAX) ? `RET_EXP_MAX : exp_val;
		limit = (`RET_PRESC_ONE << exp_eff) - `RET_PRESC_ONE;
		s_d = s_q;
		s_d.tick = 1'b0;
		if (restart) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= limit) begin
			// >= so a lowered exponent never leaves the counter stranded
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + `RET_PRESC_ONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule

// ---- design/ret_irq.sv ----
/*
 * Sticky interrupt status, enable and write-one-to-clear logic with one level output.
 * Assumes set pulses and write strobes come from logic on the same clock.
 */
`include "ret_params.svh"

module ret_irq import ret_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Event and register access
	input wire logic [7:0] set_vec,
	input wire logic en_wr,
	input wire logic clr_wr,
	input wire logic [7:0] wdata,
	// State out
	output logic [7:0] stat,
	output logic [7:0] en,
	output logic irq
);
	ret_irq_state_type s_q, s_d;

	// Set wins over a clear arriving in the same cycle
	always_comb begin
		s_d = s_q;
		if (clr_wr) begin
			s_d.stat = s_q.stat & ~wdata;
		end
		s_d.stat = (s_d.stat | set_vec) & `RET_IRQ_IMPL;
		if (en_wr) begin
			s_d.en = wdata & `RET_IRQ_IMPL;
		end
		s_d.irq = |(s_q.stat & s_q.en);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign stat = s_q.stat;
	assign en = s_q.en;
	assign irq = s_q.irq;
endmodule

// ---- design/ret_timer.sv ----
/*
 * Reader event timer: 8-bit down counter on a prescaled tick, started and stopped by
 * transceiver events or software, with APB registers and a level interrupt.
 * Assumes the event pulses and APB come from logic on core_clk; core_clk is the chip clock.
 */
`include "ret_params.svh"

module ret_timer import ret_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire ret_apb_req_type apb_req,
	output ret_apb_rsp_type apb_rsp,
	// Transceiver event pulses, observed only
	input wire ret_evt_type evt,
	// Interrupt
	output logic irq
);
	ret_main_state_type s_q, s_d;
	logic tick;
	logic start_evt;
	logic stop_evt;
	logic [7:0] idx;
	logic setup;
	logic wr_acc;
	logic mapped;
	logic [7:0] rd_byte;
	logic irq_en_wr;
	logic irq_clr_wr;
	logic [7:0] irq_set;
	logic [7:0] irq_stat;
	logic [7:0] irq_en;

	// Tick divider, restarted on every start so the first period is whole
	ret_prescaler u_presc (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.exp_val(s_q.div.tick_divider_exp),
		.restart(start_evt),
		.tick(tick)
	);

	// Sticky expiry status, enable and clear
	ret_irq u_irq (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.set_vec(irq_set),
		.en_wr(irq_en_wr),
		.clr_wr(irq_clr_wr),
		.wdata(apb_req.pwdata[7:0]),
		.stat(irq_stat),
		.en(irq_en),
		.irq(irq)
	);

	// Start and stop decode; events are only read, never fed back
	always_comb begin
		start_evt = (evt.tx_first_bit_evt & s_q.trig.start_on_tx_first_bit)
			| (evt.tx_last_bit_evt & s_q.trig.start_on_tx_last_bit)
			| s_q.cmd.sw_start_cmd;
		stop_evt = (evt.rx_first_bit_evt & s_q.trig.stop_on_rx_first_bit)
			| (evt.rx_last_bit_evt & s_q.trig.stop_on_rx_last_bit)
			| s_q.cmd.sw_stop_cmd;
	end

	// APB decode helpers
	always_comb begin
		idx = apb_req.paddr[9:2];
		setup = apb_req.psel & ~apb_req.penable;
		wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & s_q.rsp.pready & apb_req.pstrb[0];
		irq_set = '0;
		irq_set[`RET_BIT_EXPIRY] = s_q.expiry;
	end

	// Address decode and read mux; unaligned offsets are unmapped
	always_comb begin
		mapped = 1'b1;
		rd_byte = `RET_RST_BYTE;
		if (apb_req.paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (idx == `RET_IDX_AUX_STATUS) begin
			rd_byte[`RET_BIT_ACTIVE] = (s_q.run == st_run);
		end else if (idx == `RET_IDX_IRQ_EN) begin
			rd_byte = irq_en;
		end else if (idx == `RET_IDX_IRQ_STAT) begin
			rd_byte = irq_stat;
		end else if (idx == `RET_IDX_COMMAND) begin
			rd_byte[`RET_BIT_SW_START] = s_q.cmd.sw_start_cmd;
			rd_byte[`RET_BIT_SW_STOP] = s_q.cmd.sw_stop_cmd;
		end else if (idx == `RET_IDX_COUNT) begin
			rd_byte = s_q.count_field;
		end else if (idx == `RET_IDX_TICK_DIV) begin
			rd_byte = {2'h0, s_q.div};
		end else if (idx == `RET_IDX_TRIG_SEL) begin
			rd_byte = {4'h0, s_q.trig};
		end else if (idx == `RET_IDX_PRELOAD) begin
			rd_byte = s_q.preload_field;
		end else if (idx == `RET_IDX_IRQ_CLR) begin
			rd_byte = `RET_RST_BYTE; // Write-only, reads zero
		end else begin
			mapped = 1'b0;
		end
		irq_en_wr = wr_acc & mapped & (idx == `RET_IDX_IRQ_EN);
		irq_clr_wr = wr_acc & mapped & (idx == `RET_IDX_IRQ_CLR);
	end

	// Next state: counter, run state, registers and bus answer
	always_comb begin
		s_d = s_q;
		s_d.expiry = 1'b0;
		s_d.cmd = '0;
		// Counter sequencing; start is checked first so it beats a stop
		if (start_evt) begin
			s_d.count_field = s_q.preload_field;
			s_d.run = st_run;
		end else if (stop_evt) begin
			s_d.run = st_idle;
		end else begin
			case (s_q.run)
				st_run: begin
					if (tick) begin
						if (s_q.count_field == 8'h00) begin
							// A zero preload simply stops on the first tick
							s_d.run = st_idle;
						end else if (s_q.count_field == 8'h01) begin
							s_d.expiry = 1'b1;
							if (s_q.div.auto_reload_en) begin
								s_d.count_field = s_q.preload_field;
							end else begin
								s_d.count_field = 8'h00;
								s_d.run = st_idle;
							end
						end else begin
							s_d.count_field = s_q.count_field - 8'h01;
						end
					end
				end
				default: begin
					s_d.run = st_idle;
				end
			endcase
		end
		// Register writes touch settings only, never the live count
		if (wr_acc && mapped) begin
			if (idx == `RET_IDX_COMMAND) begin
				s_d.cmd.sw_start_cmd = apb_req.pwdata[`RET_BIT_SW_START];
				s_d.cmd.sw_stop_cmd = apb_req.pwdata[`RET_BIT_SW_STOP];
			end else if (idx == `RET_IDX_TICK_DIV) begin
				s_d.div = apb_req.pwdata[5:0];
			end else if (idx == `RET_IDX_TRIG_SEL) begin
				s_d.trig = apb_req.pwdata[3:0];
			end else if (idx == `RET_IDX_PRELOAD) begin
				s_d.preload_field = apb_req.pwdata[7:0];
			end
		end
		// No wait state: answer is ready in the first access cycle
		s_d.rsp.pready = setup;
		s_d.rsp.pslverr = setup & ~mapped;
		if (setup) begin
			s_d.rsp.prdata = {24'h000000, rd_byte};
		end
	end

	// Single state register, synchronous reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q.div <= `RET_RST_DIV;
			s_q.trig <= `RET_RST_TRIG;
			s_q.preload_field <= `RET_RST_BYTE;
			s_q.cmd <= '0;
			s_q.count_field <= `RET_RST_BYTE;
			s_q.run <= st_idle;
			s_q.expiry <= 1'b0;
			s_q.rsp <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp = s_q.rsp;

	// Checks on the counter and the bus
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// Quiet cycle: neither start nor stop
	logic quiet;
	assign quiet = !start_evt && !stop_evt;

	AST_START_LOADS: assert property (
		start_evt |=> (s_q.count_field == $past(s_q.preload_field)) && (s_q.run == st_run)
	) else $error("start did not load preload");

	AST_START_BEATS_STOP: assert property (
		start_evt && stop_evt |=> (s_q.run == st_run) && !s_q.expiry
	) else $error("stop beat a coinciding start");

	AST_DECREMENT: assert property (
		quiet && (s_q.run == st_run) && tick && (s_q.count_field > 8'h01)
		|=> s_q.count_field == $past(s_q.count_field) - 8'h01
	) else $error("count did not decrement by one");

	AST_AUTO_RELOAD: assert property (
		quiet && (s_q.run == st_run) && tick && (s_q.count_field == 8'h01) && s_q.div.auto_reload_en
		|=> (s_q.count_field == $past(s_q.preload_field)) && (s_q.run == st_run) && s_q.expiry
	) else $error("auto reload failed at count one");

	AST_EXPIRE: assert property (
		quiet && (s_q.run == st_run) && tick && (s_q.count_field == 8'h01) && !s_q.div.auto_reload_en
		|=> (s_q.count_field == 8'h00) && (s_q.run == st_idle) && s_q.expiry
	) else $error("expiry at zero missing");

	AST_EXPIRY_CAUSE: assert property (
		s_q.expiry |-> $past(tick) && ($past(s_q.count_field) == 8'h01) && ($past(s_q.run) == st_run)
	) else $error("expiry without a one to next transition");

	AST_STOP_SILENT: assert property (
		!start_evt && stop_evt |=> (s_q.run == st_idle) && !s_q.expiry
	) else $error("stop left timer running or flagged expiry");

	AST_HOLD: assert property (
		!start_evt && ((s_q.run == st_idle) || !tick) |=> $stable(s_q.count_field)
	) else $error("count moved without tick while active");

	AST_PRELOAD_WRITE: assert property (
		wr_acc && mapped && (idx == `RET_IDX_PRELOAD) && !start_evt && !tick
		|=> s_q.count_field == $past(s_q.count_field)
	) else $error("preload write disturbed count");

	AST_CMD_SELF_CLEAR: assert property (
		s_q.cmd.sw_start_cmd && !(wr_acc && idx == `RET_IDX_COMMAND) |=> !s_q.cmd.sw_start_cmd
	) else $error("software start bit did not clear");

	AST_IRQ_RAISE: assert property (
		s_q.expiry && irq_en[`RET_BIT_EXPIRY] ##1 irq_en[`RET_BIT_EXPIRY] |=> irq
	) else $error("enabled expiry did not raise interrupt");

	AST_COUNT_READ: assert property (
		setup && (apb_req.paddr == {`RET_IDX_COUNT, 2'h0}) |=> s_q.rsp.prdata[7:0] == $past(s_q.count_field)
	) else $error("count readback mismatch");

	AST_FAST_TICK: assert property (
		rst_n && (s_q.div.tick_divider_exp == 5'h00) && !start_evt |=> tick
	) else $error("exponent zero did not tick every cycle");

	AST_APB_ANSWER: assert property (
		setup |=> s_q.rsp.pready ##1 !s_q.rsp.pready
	) else $error("bus answer not one cycle after setup");

	// Bus answers: upper bits, bad addresses and the active flag readback
	AST_READ_UPPER_ZERO: assert property (
		s_q.rsp.pready |-> (s_q.rsp.prdata[31:8] == 24'h000000)
	) else $error("read data upper bits not zero");

	AST_BAD_ADDR_ERR: assert property (
		setup && (apb_req.paddr[1:0] != 2'h0) |=> s_q.rsp.pready && s_q.rsp.pslverr
	) else $error("unaligned access not answered with an error");

	AST_RUN_READ: assert property (
		setup && (apb_req.paddr == {`RET_IDX_AUX_STATUS, 2'h0})
		|=> s_q.rsp.prdata[`RET_BIT_ACTIVE] == ($past(s_q.run) == st_run)
	) else $error("active flag readback mismatch");

	AST_SETTING_WRITE: assert property (
		wr_acc && mapped && ((idx == `RET_IDX_TICK_DIV) || (idx == `RET_IDX_TRIG_SEL)) && !start_evt && !tick
		|=> $stable(s_q.count_field)
	) else $error("settings write disturbed count");

	// Event decode checked against the raw transceiver inputs
	AST_TX_START: assert property (
		((evt.tx_first_bit_evt && s_q.trig.start_on_tx_first_bit)
			|| (evt.tx_last_bit_evt && s_q.trig.start_on_tx_last_bit))
		|=> (s_q.run == st_run) && (s_q.count_field == $past(s_q.preload_field))
	) else $error("enabled transmit event did not start timer");

	AST_SW_START: assert property (
		s_q.cmd.sw_start_cmd |=> (s_q.run == st_run) && (s_q.count_field == $past(s_q.preload_field))
	) else $error("software start did not start timer");

	AST_IDLE_STAYS: assert property (
		(s_q.run == st_idle) && !start_evt |=> (s_q.run == st_idle)
	) else $error("timer started without a start event");

	AST_RX_STOP: assert property (
		!start_evt && ((evt.rx_first_bit_evt && s_q.trig.stop_on_rx_first_bit)
			|| (evt.rx_last_bit_evt && s_q.trig.stop_on_rx_last_bit))
		|=> (s_q.run == st_idle) && $stable(s_q.count_field)
	) else $error("enabled receive event did not stop timer");

	AST_STOP_CMD_CLEAR: assert property (
		s_q.cmd.sw_stop_cmd && !(wr_acc && idx == `RET_IDX_COMMAND) |=> !s_q.cmd.sw_stop_cmd
	) else $error("software stop bit did not clear");

	AST_ZERO_PRELOAD: assert property (
		quiet && (s_q.run == st_run) && tick && (s_q.count_field == 8'h00)
		|=> (s_q.run == st_idle) && !s_q.expiry
	) else $error("zero count did not stop quietly");

	AST_TICK_RESTART: assert property (
		start_evt |=> !tick
	) else $error("tick divider not restarted by start");

	// Interrupt path: sticky flag and level output
	AST_FLAG_SET: assert property (
		s_q.expiry |=> irq_stat[`RET_BIT_EXPIRY]
	) else $error("expiry did not set the status flag");

	AST_FLAG_HOLD: assert property (
		irq_stat[`RET_BIT_EXPIRY] && !irq_clr_wr |=> irq_stat[`RET_BIT_EXPIRY]
	) else $error("status flag dropped without a clear");

	AST_SW_STOP_NO_FLAG: assert property (
		!start_evt && s_q.cmd.sw_stop_cmd && !s_q.expiry && !irq_stat[`RET_BIT_EXPIRY]
		|=> !irq_stat[`RET_BIT_EXPIRY] ##1 !irq_stat[`RET_BIT_EXPIRY]
	) else $error("software stop raised the expiry flag");

	AST_IRQ_LEVEL: assert property (
		irq_stat[`RET_BIT_EXPIRY] && irq_en[`RET_BIT_EXPIRY] |=> irq
	) else $error("enabled flag did not hold interrupt high");

	AST_IRQ_FALL: assert property (
		!(irq_stat[`RET_BIT_EXPIRY] && irq_en[`RET_BIT_EXPIRY]) |=> !irq
	) else $error("interrupt high without an enabled flag");

	// Main scenarios
	COV_TIMEOUT: cover property (s_q.expiry && (s_q.run == st_idle));
	COV_PERIODIC: cover property (s_q.expiry && (s_q.run == st_run));
	COV_RETRIGGER: cover property ((s_q.run == st_run) && start_evt);
	COV_SW_STOP: cover property ((s_q.run == st_run) && s_q.cmd.sw_stop_cmd && !start_evt);
	COV_RX_STOP: cover property ((s_q.run == st_run) && stop_evt && !s_q.cmd.sw_stop_cmd && !start_evt);
endmodule

// ---- tb/ret_timer_tb.sv ----
/*
 * Self-checking bench for ret_timer: APB registers, event and software starts and stops, expiry interrupt.
 * Assumes ret_pkg, ret_params.svh and the design modules are compiled before it.
 */
`include "ret_params.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ret_pkg::*;

	// Bench state and design ports
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	ret_apb_req_type apb_req = '0;
	ret_apb_rsp_type apb_rsp;
	ret_evt_type evt = '0;
	logic irq;
	int fails = 0;
	int tests_run = 0;
	logic [31:0] d;
	logic e;

	ret_timer u_ret_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.evt(evt),
		.irq(irq)
	);

	// 20 MHz clock
	always #25 core_clk = ~core_clk;

	// Verdict and end of run
	task summarize;
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; holds the request until pready is seen at an edge
	task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int i;
		@(posedge core_clk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= {idx, 2'b00};
		apb_req.pwdata <= {24'h000000, wd};
		apb_req.pstrb <= 4'hF;
		@(posedge core_clk);
		apb_req.penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge core_clk);
			if (apb_rsp.pready === 1'b1)
				break;
		end
		if (apb_rsp.pready !== 1'b1) begin
			fails++;
			$display("[ERR] %0t bus timeout", $time);
			summarize();
		end
		d = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(d, exp);
	endtask

	// One-cycle transceiver event pulse; returns at the edge that samples it
	task pulse(input logic [3:0] v);
		@(posedge core_clk);
		evt <= v;
		@(posedge core_clk);
		evt <= '0;
	endtask

	// Counts edges until irq shows the wanted level; bounded
	task wait_lvl(input logic v, input int lim, output int n);
		n = 0;
		while (irq !== v && n < lim) begin
			@(posedge core_clk);
			n++;
			#1;
		end
		if (irq !== v) begin
			fails++;
			$display("[ERR] %0t irq wait timeout", $time);
			summarize();
		end
	endtask

	task t_reset;
		logic [7:0] regs [8];
		regs = '{`RET_IDX_AUX_STATUS, `RET_IDX_COUNT, `RET_IDX_PRELOAD, `RET_IDX_TICK_DIV,
			`RET_IDX_TRIG_SEL, `RET_IDX_IRQ_STAT, `RET_IDX_IRQ_EN, `RET_IDX_COMMAND};
		chk(irq, 32'h0);
		foreach (regs[i])
			rdc(regs[i], 32'h0);
		// Unmapped index answers with an error
		apb(1'b0, 8'h01, 8'h00);
		chk(e, 32'h1);
		apb(1'b1, `RET_IDX_COUNT, 8'h55);
		rdc(`RET_IDX_COUNT, 32'h0);
		apb(1'b1, `RET_IDX_PRELOAD, 8'hA5);
		rdc(`RET_IDX_PRELOAD, 32'hA5);
		apb(1'b1, `RET_IDX_TICK_DIV, 8'h3F);
		rdc(`RET_IDX_TICK_DIV, 32'h3F);
	endtask

	// One-shot timeout at two divider settings
	task t_timeout;
		int n;
		for (int x = 0; x < 3; x += 2) begin
			apb(1'b1, `RET_IDX_TICK_DIV, 8'(x));
			apb(1'b1, `RET_IDX_PRELOAD, 8'h03);
			apb(1'b1, `RET_IDX_TRIG_SEL, 8'h01);
			apb(1'b1, `RET_IDX_IRQ_EN, 8'h20);
			pulse(4'b0001);
			wait_lvl(1'b1, 100, n);
			chk(n, 3 + 3 * (1 << x));
			rdc(`RET_IDX_COUNT, 32'h0);
			rdc(`RET_IDX_AUX_STATUS, 32'h0);
			rdc(`RET_IDX_IRQ_STAT, 32'h20);
			apb(1'b1, `RET_IDX_IRQ_CLR, 8'h20);
			rdc(`RET_IDX_IRQ_STAT, 32'h0);
			chk(irq, 32'h0);
		end
	endtask

	// Auto-reload period, then software stop without an interrupt
	task t_periodic;
		int n;
		logic [31:0] c;
		apb(1'b1, `RET_IDX_TICK_DIV, 8'h22);
		apb(1'b1, `RET_IDX_PRELOAD, 8'h02);
		apb(1'b1, `RET_IDX_TRIG_SEL, 8'h00);
		apb(1'b1, `RET_IDX_COMMAND, 8'h02);
		rdc(`RET_IDX_COMMAND, 32'h0);
		wait_lvl(1'b1, 40, n);
		rdc(`RET_IDX_AUX_STATUS, 32'h80);
		apb(1'b0, `RET_IDX_COUNT, 8'h00);
		chk(32'(d == 32'h1 || d == 32'h2), 32'h1);
		apb(1'b1, `RET_IDX_IRQ_CLR, 8'h20);
		wait_lvl(1'b0, 4, n);
		wait_lvl(1'b1, 12, n);
		apb(1'b1, `RET_IDX_COMMAND, 8'h04);
		apb(1'b1, `RET_IDX_IRQ_CLR, 8'h20);
		// Window long enough for several would-be periods
		repeat (20) @(posedge core_clk);
		rdc(`RET_IDX_AUX_STATUS, 32'h0);
		rdc(`RET_IDX_IRQ_STAT, 32'h0);
		apb(1'b0, `RET_IDX_COUNT, 8'h00);
		c = d;
		rdc(`RET_IDX_COUNT, c);
	endtask

	// Both receive stop events, and a start event whose enable is clear
	task t_stop;
		logic [31:0] c;
		apb(1'b1, `RET_IDX_TICK_DIV, 8'h00);
		apb(1'b1, `RET_IDX_PRELOAD, 8'h80);
		apb(1'b1, `RET_IDX_TRIG_SEL, 8'h0E);
		for (int k = 2; k < 4; k++) begin
			pulse(4'b0010);
			rdc(`RET_IDX_AUX_STATUS, 32'h80);
			pulse(4'b0001 << k);
			apb(1'b0, `RET_IDX_COUNT, 8'h00);
			c = d;
			rdc(`RET_IDX_COUNT, c);
			chk(32'(c < 32'h80 && c > 32'h0), 32'h1);
			rdc(`RET_IDX_AUX_STATUS, 32'h0);
			rdc(`RET_IDX_IRQ_STAT, 32'h0);
		end
		pulse(4'b0001);
		rdc(`RET_IDX_AUX_STATUS, 32'h0);
	endtask

	// Slow tick so reads land before the first decrement
	task t_retrig;
		apb(1'b1, `RET_IDX_TICK_DIV, 8'h05);
		apb(1'b1, `RET_IDX_PRELOAD, 8'hF0);
		apb(1'b1, `RET_IDX_TRIG_SEL, 8'h05);
		pulse(4'b0001);
		apb(1'b1, `RET_IDX_PRELOAD, 8'h10);
		rdc(`RET_IDX_COUNT, 32'hF0);
		pulse(4'b0001);
		rdc(`RET_IDX_COUNT, 32'h10);
		pulse(4'b0101);
		rdc(`RET_IDX_AUX_STATUS, 32'h80);
		rdc(`RET_IDX_COUNT, 32'h10);
		apb(1'b1, `RET_IDX_COMMAND, 8'h06);
		rdc(`RET_IDX_AUX_STATUS, 32'h80);
		apb(1'b1, `RET_IDX_COMMAND, 8'h04);
		rdc(`RET_IDX_AUX_STATUS, 32'h0);
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_timeout();
		t_periodic();
		t_stop();
		t_retrig();
		summarize();
	end
endmodule
